// ==== design/pcmsd_top.sv ====
// pc card memory space decoder: rom strobes and config registers
`default_nettype none
module pcmsd_top
	import pcmsd_pkg::*;
#(
	parameter int ROM_KB = 128 // attached rom size in kilobytes
) (
	input wire logic mclk, // system clock
	input wire logic rst_n, // synchronous reset, active low
	input wire pcmsd_pkg::pcmsd_ctl_t ctl_pins, // host strobes, raw
	input wire logic [10:0] card_addr, // host address, bit0 is card_addr_bit0
	input wire logic [7:0] card_data_low_in, // low data lanes from host
	input wire logic [7:0] card_data_high_in, // high data lanes, unused
	input wire logic [7:0] rom_data_in, // data from rom
	output logic [7:0] card_data_low_out, // low data lanes to host
	output logic card_data_low_oe, // drive low lanes
	output logic [7:0] card_data_high_out, // high lanes, never valid
	output logic card_data_high_oe, // drive high lanes
	output pcmsd_pkg::pcmsd_rom_t rom_ctl, // rom strobes and extension
	output logic power_down_request, // status power-down bit
	output logic io_space_cycle // i/o space access for lan core
);
	import pcmsd_pkg::*;

	localparam bit COMMON_OK = (ROM_KB > PCMSD_MIN_ROM_KB);

	pcmsd_ctl_t c;
	logic [10:0] a;
	logic [7:0] dl;
	logic [7:0] rd;

	// all pins cross two flops before decode
	pcmsd_sync #(.W(7), .INIT(7'h7F)) u_sync_ctl (
		.mclk(mclk),
		.rst_n(rst_n),
		.d(ctl_pins),
		.q(c)
	);
	pcmsd_sync #(.W(11)) u_sync_addr (
		.mclk(mclk),
		.rst_n(rst_n),
		.d(card_addr),
		.q(a)
	);
	pcmsd_sync #(.W(8)) u_sync_dl (
		.mclk(mclk),
		.rst_n(rst_n),
		.d(card_data_low_in),
		.q(dl)
	);
	pcmsd_sync #(.W(8)) u_sync_rom (
		.mclk(mclk),
		.rst_n(rst_n),
		.d(rom_data_in),
		.q(rd)
	);

	// registered state
	typedef struct packed {
		pcmsd_space_t space;
		logic wr_seen;
		pcmsd_rom_t rom;
		logic [7:0] dlo;
		logic dlo_oe;
	} pcmsd_state_t;
	pcmsd_state_t st_q, st_d;

	logic byte_cyc, word_cyc, read_cyc, write_cyc, even, in_ccr, in_cis;
	logic [3:0] ccr_wr;
	logic [7:0] opt_v, stat_v, pin_v, sock_v, ccr_rd;
	pcmsd_space_t space;

	// cycle shape from the enables
	always_comb begin
		byte_cyc = !c.ce1_n && c.ce2_n;
		word_cyc = !c.ce1_n && !c.ce2_n;
		read_cyc = !c.oe_n && c.we_n;
		write_cyc = !c.we_n && c.oe_n;
		even = !a[0];
		in_cis = a <= PCMSD_CIS_LAST; // see RL3
		in_ccr = a >= PCMSD_CCR_OPTION && a <= PCMSD_CCR_SOCKET; // see RL4
	end

	// space decode: i/o strobes mean i/o whatever reg says; else reg high means memory, low means attribute
	always_comb begin
		space = PCMSD_IDLE; // see RL1
		if (!c.ce1_n || !c.ce2_n) begin
			if (!c.iord_n || !c.iowr_n) begin
				space = PCMSD_IO; // see RL2
			end else if (c.reg_n) begin
				space = COMMON_OK ? PCMSD_COMMON : PCMSD_IDLE; // see RL8
			end else if (in_ccr) begin
				space = PCMSD_CCR;
			end else if (in_cis) begin
				space = PCMSD_CIS;
			end
		end
	end

	// one write per strobe, even address or word cycle, low byte only;
	// a word cycle counts as its even byte whatever the address bit says
	always_comb begin
		ccr_wr = 4'h0;
		if (space == PCMSD_CCR && write_cyc && !st_q.wr_seen &&
			(even || word_cyc)) begin
			ccr_wr[a[2:1]] = 1'b1; // see RL14, RL5
		end
	end

	pcmsd_ccr #(.RST(PCMSD_OPTION_RST), .WMASK(PCMSD_OPTION_WMASK),
		.FIXED(PCMSD_OPTION_RMASK)) u_opt (
		.mclk(mclk), .rst_n(rst_n), .wr(ccr_wr[0]), .wdata(dl),
		.value(opt_v));
	pcmsd_ccr #(.RST(PCMSD_STATUS_RST), .WMASK(PCMSD_STATUS_WMASK),
		.FIXED(8'h00)) u_stat (
		.mclk(mclk), .rst_n(rst_n), .wr(ccr_wr[1]), .wdata(dl),
		.value(stat_v));
	pcmsd_ccr #(.RST(PCMSD_PINREP_RST)) u_pin (
		.mclk(mclk), .rst_n(rst_n), .wr(ccr_wr[2]), .wdata(dl),
		.value(pin_v));
	pcmsd_ccr #(.RST(PCMSD_SOCKET_RST)) u_sock (
		.mclk(mclk), .rst_n(rst_n), .wr(ccr_wr[3]), .wdata(dl),
		.value(sock_v));

	// register read mux by word index
	always_comb begin
		case (a[2:1])
			2'h0: ccr_rd = opt_v;
			2'h1: ccr_rd = stat_v;
			2'h2: ccr_rd = pin_v;
			2'h3: ccr_rd = sock_v;
			default: ccr_rd = 8'h00;
		endcase
	end

	// next rom strobes and data lanes
	always_comb begin
		st_d = st_q;
		st_d.space = space;
		st_d.wr_seen = write_cyc && space != PCMSD_IDLE;
		st_d.rom = '{rom_select_n: 1'b1, rom_read_n: 1'b1,
			rom_addr_extension: 1'b0}; // see RL15
		st_d.dlo = 8'h00;
		st_d.dlo_oe = 1'b0; // see RL19
		case (space)
			PCMSD_COMMON: begin
				// bytes only, either address parity; word/high keep strobes high
				if (byte_cyc && read_cyc) begin
					st_d.rom.rom_select_n = 1'b0; // see RL9, RL7
					st_d.rom.rom_read_n = 1'b0;
					st_d.dlo = rd;
					st_d.dlo_oe = 1'b1;
				end else if (byte_cyc && write_cyc) begin
					st_d.rom.rom_select_n = 1'b0; // see RL10
				end
			end
			PCMSD_CIS: begin
				if ((even || word_cyc) && read_cyc) begin
					st_d.rom.rom_select_n = 1'b0; // see RL11, RL6
					st_d.rom.rom_read_n = 1'b0;
					st_d.dlo = rd;
					st_d.dlo_oe = 1'b1;
				end else if ((even || word_cyc) && write_cyc) begin
					st_d.rom.rom_select_n = 1'b0; // see RL12
				end
			end
			PCMSD_CCR: begin
				if ((even || word_cyc) && read_cyc) begin
					st_d.dlo = ccr_rd; // see RL13
					st_d.dlo_oe = 1'b1;
				end
			end
			PCMSD_IO: begin
				// i/o cycle only raises the extension; rom strobes stay high
				st_d.rom.rom_addr_extension = 1'b1;
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st_q <= '{space: PCMSD_IDLE, wr_seen: 1'b0,
				rom: '{rom_select_n: 1'b1, rom_read_n: 1'b1,
				rom_addr_extension: 1'b0}, dlo: 8'h00, dlo_oe: 1'b0};
		end else begin
			st_q <= st_d;
		end
	end

	// high lanes never valid in any decoded space, so never driven
	assign card_data_high_out = 8'h00; // see RL6
	assign card_data_high_oe = 1'b0; // see RL19
	assign card_data_low_out = st_q.dlo;
	assign card_data_low_oe = st_q.dlo_oe;
	assign rom_ctl = st_q.rom;
	assign power_down_request = stat_v[PCMSD_STATUS_PWRDN_BIT];
	assign io_space_cycle = st_q.space == PCMSD_IO;

	// checks: those on space sample the unflopped decode, so each answer is looked
	// for one edge after the cycle that asks for it
	a_rom_read_pair: assert property (@(posedge mclk) // see RL10
		disable iff (!rst_n)
		!rom_ctl.rom_read_n |-> !rom_ctl.rom_select_n)
		else $error("rom read without select");
	a_ccr_no_rom: assert property (@(posedge mclk) // see RL13
		disable iff (!rst_n)
		st_q.space == PCMSD_CCR |-> rom_ctl.rom_select_n)
		else $error("rom selected in register range");
	a_mem_ext_low: assert property (@(posedge mclk) // see RL15
		disable iff (!rst_n)
		st_q.space inside {PCMSD_COMMON, PCMSD_CIS, PCMSD_CCR}
		|-> !rom_ctl.rom_addr_extension)
		else $error("extension high in memory space");
	// common memory: only byte cycles reach the rom
	a_common_word_idle: assert property (@(posedge mclk) // see RL10
		disable iff (!rst_n)
		space == PCMSD_COMMON && !byte_cyc
		|=> rom_ctl.rom_select_n)
		else $error("rom selected on word common cycle");
	a_common_rd_strobe: assert property (@(posedge mclk) // see RL9
		disable iff (!rst_n)
		space == PCMSD_COMMON && byte_cyc && read_cyc
		|=> !rom_ctl.rom_read_n && card_data_low_oe)
		else $error("common byte read missed strobes");
	a_common_wr_strobe: assert property (@(posedge mclk) // see RL10
		disable iff (!rst_n)
		space == PCMSD_COMMON && byte_cyc && write_cyc
		|=> !rom_ctl.rom_select_n && rom_ctl.rom_read_n)
		else $error("common byte write missed select");
	// attribute space: the rom holds the cis, the registers are local
	a_cis_even_read: assert property (@(posedge mclk) // see RL11
		disable iff (!rst_n)
		space == PCMSD_CIS && read_cyc && (even || word_cyc)
		|=> !rom_ctl.rom_select_n && !rom_ctl.rom_read_n)
		else $error("cis read missed strobes");
	a_cis_odd_idle: assert property (@(posedge mclk) // see RL11
		disable iff (!rst_n)
		space == PCMSD_CIS && byte_cyc && !even
		|=> rom_ctl.rom_select_n && !card_data_low_oe)
		else $error("odd cis byte touched rom");
	a_cis_write_sel: assert property (@(posedge mclk) // see RL12
		disable iff (!rst_n)
		space == PCMSD_CIS && write_cyc && (even || word_cyc)
		|=> !rom_ctl.rom_select_n && rom_ctl.rom_read_n)
		else $error("cis write missed select");
	a_cis_odd_write: assert property (@(posedge mclk) // see RL12
		disable iff (!rst_n)
		space == PCMSD_CIS && write_cyc && byte_cyc && !even
		|=> rom_ctl.rom_select_n)
		else $error("odd cis write selected rom");
	a_ccr_read_data: assert property (@(posedge mclk) // see RL13
		disable iff (!rst_n)
		space == PCMSD_CCR && read_cyc && (even || word_cyc)
		|=> card_data_low_oe && card_data_low_out == $past(ccr_rd))
		else $error("register read data wrong");
	a_ccr_odd_read: assert property (@(posedge mclk) // see RL5
		disable iff (!rst_n)
		space == PCMSD_CCR && read_cyc && byte_cyc && !even
		|=> !card_data_low_oe)
		else $error("odd register byte driven");
	a_ccr_odd_write: assert property (@(posedge mclk) // see RL14
		disable iff (!rst_n)
		space == PCMSD_CCR && !even && byte_cyc
		|=> $stable({opt_v, stat_v, pin_v, sock_v}))
		else $error("odd register write took effect");
	a_ccr_socket_write: assert property (@(posedge mclk) // see RL14
		disable iff (!rst_n)
		space == PCMSD_CCR && write_cyc && !st_q.wr_seen
		&& a == PCMSD_CCR_SOCKET
		|=> sock_v == $past(dl))
		else $error("socket register write lost");
	// remaining checks: writes never read the rom, i/o and idle cycles never select it, lanes float outside reads
	a_write_no_read: assert property (@(posedge mclk) // see RL12
		disable iff (!rst_n)
		write_cyc && space != PCMSD_IDLE
		|=> rom_ctl.rom_read_n && !card_data_low_oe)
		else $error("rom read during a write");
	a_io_flag: assert property (@(posedge mclk) // see RL2
		disable iff (!rst_n)
		space == PCMSD_IO
		|=> io_space_cycle && rom_ctl.rom_select_n)
		else $error("i/o cycle not flagged");
	a_idle_float: assert property (@(posedge mclk) // see RL19
		disable iff (!rst_n)
		space == PCMSD_IDLE
		|=> !card_data_low_oe && rom_ctl.rom_select_n)
		else $error("idle cycle drove lanes or rom");
	a_low_oe_read: assert property (@(posedge mclk) // see RL19
		disable iff (!rst_n)
		card_data_low_oe |-> $past(read_cyc))
		else $error("low lanes driven outside a read");
	a_high_lane_off: assert property (@(posedge mclk) // see RL6
		disable iff (!rst_n)
		!card_data_high_oe)
		else $error("high lanes driven");
	a_no_common_small: assert property (@(posedge mclk) // see RL8
		disable iff (!rst_n)
		!COMMON_OK |-> st_q.space != PCMSD_COMMON)
		else $error("common memory on small rom");
	a_opt_level_bit: assert property (@(posedge mclk) // see RL4
		disable iff (!rst_n)
		(opt_v & PCMSD_OPTION_RMASK) == PCMSD_OPTION_RMASK)
		else $error("level interrupt bit lost");
endmodule // pcmsd_top
`default_nettype wire

// ==== design/pcmsd_pkg.sv ====
// constants and carrier types for the pc card memory space decoder
// Notes on behaviour
// RL1 - three decoded spaces: common memory, i/o space, attribute memory
// RL2 - i/o space maps lan registers, card control, optional rom id number
// RL3 - card information structure sits in attribute memory from 000 to 7EE
// RL4 - four config registers at 7F0, 7F2, 7F4, 7F6 in attribute memory
// RL5 - attribute memory byte wide at even addresses; odd addresses carry nothing
// RL6 - 16-bit attribute access: only low data byte valid
// RL7 - common memory takes byte accesses at even and odd addresses
// RL8 - common memory above cis; absent when rom below two kilobytes (the code also drops it when ROM_KB is exactly two)
// RL9 - common byte read drives rom select and rom read low
// RL10 - common byte write: select low, read high; word/high cycles keep both high
// RL11 - cis read at even address or 16-bit: strobes low, even byte returned
// RL12 - cis write at even address or 16-bit: select low, read high
// RL13 - config register reads keep rom strobes high, low byte at even address
// RL14 - config register writes store low byte at even addresses only
// RL15 - rom address extension held low for memory-space accesses
// RL16 - host asserts i/o write and write enable to write id region
// RL17 - host avoids power-down while polled rom write still runs
// RL18 - host avoids whole-chip erase and protects attribute contents
// RL19 - invalid data lanes are floated during host cycles
`default_nettype none
package pcmsd_pkg;
	localparam logic [10:0] PCMSD_CIS_FIRST = 11'h000;
	localparam logic [10:0] PCMSD_CIS_LAST = 11'h7EE;
	localparam logic [10:0] PCMSD_CCR_OPTION = 11'h7F0;
	localparam logic [10:0] PCMSD_CCR_STATUS = 11'h7F2;
	localparam logic [10:0] PCMSD_CCR_PINREP = 11'h7F4;
	localparam logic [10:0] PCMSD_CCR_SOCKET = 11'h7F6;
	localparam logic [7:0] PCMSD_OPTION_RST = 8'h40;
	localparam logic [7:0] PCMSD_OPTION_WMASK = 8'hBF;
	localparam logic [7:0] PCMSD_OPTION_RMASK = 8'h40;
	localparam logic [7:0] PCMSD_STATUS_RST = 8'h00;
	localparam logic [7:0] PCMSD_STATUS_WMASK = 8'h24;
	localparam int PCMSD_STATUS_PWRDN_BIT = 2;
	localparam logic [7:0] PCMSD_PINREP_RST = 8'h00;
	localparam logic [7:0] PCMSD_SOCKET_RST = 8'h00;
	localparam int PCMSD_MIN_ROM_KB = 2;

	// host control pins, raw or synchronised, active low as on the card bus
	typedef struct packed {
		logic reg_n;
		logic ce1_n;
		logic ce2_n;
		logic oe_n;
		logic we_n;
		logic iord_n;
		logic iowr_n;
	} pcmsd_ctl_t;

	// decoded cycle
	typedef enum logic [2:0] {
		PCMSD_IDLE,
		PCMSD_COMMON,
		PCMSD_CIS,
		PCMSD_CCR,
		PCMSD_IO
	} pcmsd_space_t;

	typedef struct packed {
		logic rom_select_n;
		logic rom_read_n;
		logic rom_addr_extension;
	} pcmsd_rom_t;
endpackage : pcmsd_pkg
`default_nettype wire

// ==== design/pcmsd_sync.sv ====
// two-flop synchroniser for a bus of pin inputs
`default_nettype none
module pcmsd_sync #(
	parameter int W = 8,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic mclk, // system clock
	input wire logic rst_n, // synchronous reset
	input wire logic [W-1:0] d, // asynchronous pins
	output logic [W-1:0] q // synchronised copy
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} pcmsd_sync_t;
	pcmsd_sync_t st_q, st_d;

	// first stage feeds only the second
	always_comb begin
		st_d.s1 = d;
		st_d.s2 = st_q.s1;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st_q <= {INIT, INIT};
		end else begin
			st_q <= st_d;
		end
	end

	assign q = st_q.s2;
endmodule // pcmsd_sync
`default_nettype wire

// ==== design/pcmsd_ccr.sv ====
// one card configuration register with write mask and fixed bits
`default_nettype none
module pcmsd_ccr #(
	parameter logic [7:0] RST = 8'h00,
	parameter logic [7:0] WMASK = 8'hFF,
	parameter logic [7:0] FIXED = 8'h00
) (
	input wire logic mclk, // system clock
	input wire logic rst_n, // synchronous reset
	input wire logic wr, // one-cycle write strobe
	input wire logic [7:0] wdata, // low data byte
	output logic [7:0] value // register contents
);
	logic [7:0] r_q, r_d;

	// only writable bits change; fixed bits always read their constant
	always_comb begin
		r_d = r_q;
		if (wr) begin
			r_d = (r_q & ~WMASK) | (wdata & WMASK);
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			r_q <= RST;
		end else begin
			r_q <= r_d;
		end
	end

	assign value = (r_q & ~FIXED) | FIXED;
endmodule // pcmsd_ccr
`default_nettype wire

// ==== verification/pcmsd_rom_model.sv ====
// external rom model: byte memory behind the block's rom strobes
`default_nettype none
module pcmsd_rom_model
	import pcmsd_pkg::*;
(
	input wire logic mclk, // system clock
	input wire pcmsd_pkg::pcmsd_rom_t rom_ctl, // strobes from the block
	input wire logic [10:0] addr, // host address lines
	input wire logic [7:0] wdata, // host low data lanes
	output logic [7:0] rdata // rom data bus
);
	import pcmsd_pkg::*;
	logic [7:0] mem [0:4095];
	logic [11:0] a;
	// preload a known pattern so reads can be predicted
	initial begin
		rdata = 8'h00;
		for (int i = 0; i < 4096; i++) begin
			mem[i] = i[7:0] ^ 8'h3C;
		end
	end
	// extension output is wired to the top rom address line
	assign a = {rom_ctl.rom_addr_extension, addr};
	// idle bus flips every cycle, so a stale byte can never pass
	always @(posedge mclk) begin
		if (!rom_ctl.rom_select_n && !rom_ctl.rom_read_n) begin
			rdata <= mem[a];
		end else begin
			rdata <= ~rdata;
		end
		// one byte per write cycle: no whole-chip erase is ever issued
		if (!rom_ctl.rom_select_n && rom_ctl.rom_read_n) begin
			mem[a] <= wdata;
		end
	end
endmodule // pcmsd_rom_model
`default_nettype wire

// ==== verification/pcmsd_top_tb.sv ====
// self-checking bench for the memory space decoder
`default_nettype none
module pcmsd_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import pcmsd_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	pcmsd_ctl_t ctl_pins = 7'h7F;
	logic [10:0] card_addr = 11'h000;
	logic [7:0] din = 8'h00;
	logic [7:0] rom_data;
	logic [7:0] dout;
	logic [7:0] dhi;
	logic doe;
	logic dhoe;
	logic pwr;
	logic io_cyc;
	pcmsd_rom_t rom_ctl;
	pcmsd_rom_t rom_ctl_s;
	logic doe_s;
	int n_mismatch = 0;
	int total_checks = 0;

	initial begin
		forever #10 mclk = ~mclk;
	end

	pcmsd_top #(.ROM_KB(128)) i_dut (
		.mclk(mclk),
		.rst_n(rst_n),
		.ctl_pins(ctl_pins),
		.card_addr(card_addr),
		.card_data_low_in(din),
		.card_data_high_in(~din),
		.rom_data_in(rom_data),
		.card_data_low_out(dout),
		.card_data_low_oe(doe),
		.card_data_high_out(dhi),
		.card_data_high_oe(dhoe),
		.rom_ctl(rom_ctl),
		.power_down_request(pwr),
		.io_space_cycle(io_cyc)
	);

	pcmsd_rom_model i_rom (
		.mclk(mclk),
		.rom_ctl(rom_ctl),
		.addr(card_addr),
		.wdata(din),
		.rdata(rom_data)
	);

	// same pins into a card whose rom is too small for common memory
	pcmsd_top #(.ROM_KB(PCMSD_MIN_ROM_KB)) i_dut_small (
		.mclk(mclk),
		.rst_n(rst_n),
		.ctl_pins(ctl_pins),
		.card_addr(card_addr),
		.card_data_low_in(din),
		.card_data_high_in(~din),
		.rom_data_in(rom_data),
		.card_data_low_out(),
		.card_data_low_oe(doe_s),
		.card_data_high_out(),
		.card_data_high_oe(),
		.rom_ctl(rom_ctl_s),
		.power_down_request(),
		.io_space_cycle()
	);

	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic ok, input string m);
		total_checks++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("MISMATCH t=%0t %s", $time, m);
		end
	endtask

	// preloaded rom content for an address
	function automatic logic [7:0] pat(input logic [10:0] a);
		return a[7:0] ^ 8'h3C;
	endfunction

	// one host cycle; address settles before strobes, as writes need
	task automatic acc(input logic [6:0] c, input logic [10:0] a,
		input logic [7:0] d, input logic [2:0] er, input logic eoe,
		input logic [7:0] ed);
		card_addr = a;
		din = d;
		repeat (4) @(posedge mclk);
		#1 ctl_pins = pcmsd_ctl_t'(c);
		// rom answers a cycle late, so allow sync plus rom latency
		repeat (8) @(posedge mclk);
		#1 chk(rom_ctl === er && dhoe === 1'b0, "strobes");
		chk(dhi === 8'h00, "high lanes");
		chk(io_cyc === (c[1:0] != 2'b11), "io flag");
		if (c[1:0] == 2'b11)
			chk(doe === eoe && (!eoe || dout === ed), "data");
		// a small rom leaves common memory undecoded
		if (c[6] && c[1:0] == 2'b11)
			chk(rom_ctl_s === 3'b110 && doe_s === 1'b0, "small");
		else
			chk(rom_ctl_s === er, "small attr");
		ctl_pins = 7'h7F;
		repeat (5) @(posedge mclk);
		#1 chk(rom_ctl === 3'b110 && doe === 1'b0, "release");
	endtask

	task automatic t_reset;
		repeat (5) @(posedge mclk);
		#1 rst_n = 1'b1;
		repeat (3) @(posedge mclk);
		#1 chk(rom_ctl === 3'b110 && pwr === 1'b0 && doe === 1'b0, "reset");
	endtask

	// byte reads at even and odd addresses, a write, word and high-only cycles
	task automatic t_common;
		acc(7'h57, 11'h010, 8'h00, 3'b000, 1'b1, pat(11'h010));
		acc(7'h57, 11'h011, 8'h00, 3'b000, 1'b1, pat(11'h011));
		// no power-down is requested while this write stands
		acc(7'h5B, 11'h021, 8'hC3, 3'b010, 1'b0, 8'h00);
		acc(7'h57, 11'h021, 8'h00, 3'b000, 1'b1, 8'hC3);
		acc(7'h47, 11'h022, 8'h00, 3'b110, 1'b0, 8'h00);
		acc(7'h67, 11'h023, 8'h00, 3'b110, 1'b0, 8'h00);
	endtask

	task automatic t_cis;
		acc(7'h17, 11'h7EE, 8'h00, 3'b000, 1'b1, pat(11'h7EE));
		acc(7'h17, 11'h013, 8'h00, 3'b110, 1'b0, 8'h00);
		acc(7'h07, 11'h020, 8'h00, 3'b000, 1'b1, pat(11'h020));
		acc(7'h1B, 11'h030, 8'h5A, 3'b010, 1'b0, 8'h00);
		acc(7'h17, 11'h030, 8'h00, 3'b000, 1'b1, 8'h5A);
		acc(7'h1B, 11'h031, 8'h77, 3'b110, 1'b0, 8'h00);
		acc(7'h0B, 11'h040, 8'h66, 3'b010, 1'b0, 8'h00);
		acc(7'h07, 11'h040, 8'h00, 3'b000, 1'b1, 8'h66);
	endtask

	task automatic t_ccr;
		logic [10:0] ra;
		// reset contents of all four registers
		for (int i = 0; i < 4; i++) begin
			ra = 11'h7F0 + 11'(2 * i);
			acc(7'h17, ra, 8'h00, 3'b110, 1'b1, (i == 0) ? 8'h40 : 8'h00);
		end
		acc(7'h1B, 11'h7F2, 8'hFF, 3'b110, 1'b0, 8'h00);
		chk(pwr === 1'b1, "power down set");
		acc(7'h17, 11'h7F2, 8'h00, 3'b110, 1'b1, 8'h24);
		acc(7'h07, 11'h7F2, 8'h00, 3'b110, 1'b1, 8'h24);
		acc(7'h17, 11'h7F3, 8'h00, 3'b110, 1'b0, 8'h00);
		acc(7'h1B, 11'h7F0, 8'h00, 3'b110, 1'b0, 8'h00);
		acc(7'h17, 11'h7F0, 8'h00, 3'b110, 1'b1, 8'h40);
		acc(7'h1B, 11'h7F5, 8'hAA, 3'b110, 1'b0, 8'h00);
		acc(7'h17, 11'h7F4, 8'h00, 3'b110, 1'b1, 8'h00);
		acc(7'h0B, 11'h7F6, 8'hA5, 3'b110, 1'b0, 8'h00);
		acc(7'h17, 11'h7F6, 8'h00, 3'b110, 1'b1, 8'hA5);
		acc(7'h1B, 11'h7F2, 8'h00, 3'b110, 1'b0, 8'h00);
		chk(pwr === 1'b0, "power down clear");
	endtask

	task automatic t_io;
		acc(7'h1D, 11'h7F0, 8'h00, 3'b111, 1'b0, 8'h00);
		// id region write drives both write strobes low together
		acc(7'h1A, 11'h100, 8'h11, 3'b111, 1'b0, 8'h00);
	endtask

	// hang guard: far beyond the few hundred cycles the run needs
	initial begin
		#100000;
		n_mismatch++;
		close_out();
	end

	initial begin
		t_reset();
		t_common();
		t_cis();
		t_ccr();
		t_io();
		close_out();
	end
endmodule // pcmsd_top_tb
`default_nettype wire
